// *** core/query_resp_pkg.sv ***
// Constants shared by the query responder files
package query_resp_pkg;

    // Bus and array geometry
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 26;
    localparam int PART_CNT = 8;
    localparam int PART_W = 3;
    localparam int BLOCK_OFS_W = 17;
    localparam int DB_OFS_W = 9;

    // Command codes on the data bus
    localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
    localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 16'h00FF;

    // Mode after reset: normal array reads
    localparam logic MODE_QUERY_RESET = 1'b0;
    localparam logic WE_N_RESET = 1'b1;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic OE_RESET = 1'b0;

    // Fixed fills
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] UPPER_BYTE = 8'h00;

    // Block state word
    localparam logic [BLOCK_OFS_W-1:0] OFS_BLOCK_STATE = 17'h00002;
    localparam int BSW_LOCKED_BIT = 0;
    localparam int BSW_LOCKDOWN_BIT = 1;

    // Query database offsets (word addresses)
    localparam logic [DB_OFS_W-1:0] OFS_SIG_Q = 9'h010;
    localparam logic [DB_OFS_W-1:0] OFS_SIG_R = 9'h011;
    localparam logic [DB_OFS_W-1:0] OFS_SIG_Y = 9'h012;
    localparam logic [DB_OFS_W-1:0] OFS_PSET_LO = 9'h013;
    localparam logic [DB_OFS_W-1:0] OFS_PSET_HI = 9'h014;
    localparam logic [DB_OFS_W-1:0] OFS_PTAB_LO = 9'h015;
    localparam logic [DB_OFS_W-1:0] OFS_PTAB_HI = 9'h016;
    localparam logic [DB_OFS_W-1:0] OFS_ASET_LO = 9'h017;
    localparam logic [DB_OFS_W-1:0] OFS_ASET_HI = 9'h018;
    localparam logic [DB_OFS_W-1:0] OFS_STAB_LO = 9'h019;
    localparam logic [DB_OFS_W-1:0] OFS_STAB_HI = 9'h01A;
    localparam logic [DB_OFS_W-1:0] OFS_VCC_MIN = 9'h01B;
    localparam logic [DB_OFS_W-1:0] OFS_VCC_MAX = 9'h01C;
    localparam logic [DB_OFS_W-1:0] OFS_VPP_MIN = 9'h01D;
    localparam logic [DB_OFS_W-1:0] OFS_VPP_MAX = 9'h01E;
    localparam logic [DB_OFS_W-1:0] OFS_TYP_WORD = 9'h01F;
    localparam logic [DB_OFS_W-1:0] OFS_TYP_BUF = 9'h020;
    localparam logic [DB_OFS_W-1:0] OFS_TYP_BLK = 9'h021;
    localparam logic [DB_OFS_W-1:0] OFS_TYP_CHIP = 9'h022;
    localparam logic [DB_OFS_W-1:0] OFS_MAX_WORD = 9'h023;
    localparam logic [DB_OFS_W-1:0] OFS_MAX_BUF = 9'h024;
    localparam logic [DB_OFS_W-1:0] OFS_MAX_BLK = 9'h025;
    localparam logic [DB_OFS_W-1:0] OFS_MAX_CHIP = 9'h026;
    localparam logic [DB_OFS_W-1:0] OFS_SIZE = 9'h027;
    localparam logic [DB_OFS_W-1:0] OFS_IFW_LO = 9'h028;
    localparam logic [DB_OFS_W-1:0] OFS_IFW_HI = 9'h029;
    localparam logic [DB_OFS_W-1:0] OFS_WBUF_LO = 9'h02A;
    localparam logic [DB_OFS_W-1:0] OFS_WBUF_HI = 9'h02B;
    localparam logic [DB_OFS_W-1:0] OFS_REGION_CNT = 9'h02C;
    localparam logic [DB_OFS_W-1:0] OFS_REGION_B0 = 9'h02D;
    localparam logic [DB_OFS_W-1:0] OFS_REGION_B1 = 9'h02E;
    localparam logic [DB_OFS_W-1:0] OFS_REGION_B2 = 9'h02F;
    localparam logic [DB_OFS_W-1:0] OFS_REGION_B3 = 9'h030;
    localparam logic [DB_OFS_W-1:0] OFS_EXT_P = 9'h10A;
    localparam logic [DB_OFS_W-1:0] OFS_EXT_R = 9'h10B;
    localparam logic [DB_OFS_W-1:0] OFS_EXT_I = 9'h10C;
    localparam logic [DB_OFS_W-1:0] OFS_EXT_MAJOR = 9'h10D;
    localparam logic [DB_OFS_W-1:0] OFS_EXT_MINOR = 9'h10E;
    localparam logic [DB_OFS_W-1:0] OFS_FEAT_B0 = 9'h10F;
    localparam logic [DB_OFS_W-1:0] OFS_FEAT_B1 = 9'h110;
    localparam logic [DB_OFS_W-1:0] OFS_FEAT_B2 = 9'h111;
    localparam logic [DB_OFS_W-1:0] OFS_FEAT_B3 = 9'h112;
    localparam logic [DB_OFS_W-1:0] OFS_SUSPEND = 9'h113;
    localparam logic [DB_OFS_W-1:0] OFS_BSW_MASK_LO = 9'h114;
    localparam logic [DB_OFS_W-1:0] OFS_BSW_MASK_HI = 9'h115;

    // Database byte values
    localparam logic [BYTE_W-1:0] VAL_SIG_Q = 8'h51;
    localparam logic [BYTE_W-1:0] VAL_SIG_R = 8'h52;
    localparam logic [BYTE_W-1:0] VAL_SIG_Y = 8'h59;
    localparam logic [DATA_W-1:0] VAL_PRIMARY_SET_ID = 16'h00A5; // Arbitrary value
    localparam logic [DATA_W-1:0] VAL_PRIMARY_TABLE = 16'h010A;
    localparam logic [DATA_W-1:0] VAL_ALTERNATE_SET_ID = 16'h0000;
    localparam logic [DATA_W-1:0] VAL_SECONDARY_TABLE = 16'h0000;
    localparam logic [BYTE_W-1:0] VAL_VCC_MIN = 8'h17;
    localparam logic [BYTE_W-1:0] VAL_VCC_MAX = 8'h20;
    localparam logic [BYTE_W-1:0] VAL_VPP_MIN = 8'h85;
    localparam logic [BYTE_W-1:0] VAL_VPP_MAX = 8'h95;
    localparam logic [BYTE_W-1:0] VAL_TYP_WORD = 8'h06;
    localparam logic [BYTE_W-1:0] VAL_TYP_BUF_LONG = 8'h0B;
    localparam logic [BYTE_W-1:0] VAL_TYP_BUF_SHORT = 8'h0A;
    localparam logic [BYTE_W-1:0] VAL_TYP_BLK = 8'h0A;
    localparam logic [BYTE_W-1:0] VAL_TYP_CHIP = 8'h00;
    localparam logic [BYTE_W-1:0] VAL_MAX_WORD = 8'h02;
    localparam logic [BYTE_W-1:0] VAL_MAX_BUF_WIDE = 8'h02;
    localparam logic [BYTE_W-1:0] VAL_MAX_BUF_NARROW = 8'h01;
    localparam logic [BYTE_W-1:0] VAL_MAX_BLK = 8'h02;
    localparam logic [BYTE_W-1:0] VAL_MAX_CHIP = 8'h00;
    localparam logic [BYTE_W-1:0] VAL_SIZE_128M = 8'h18;
    localparam logic [BYTE_W-1:0] VAL_SIZE_256M = 8'h19;
    localparam logic [BYTE_W-1:0] VAL_SIZE_512M = 8'h1A;
    localparam logic [BYTE_W-1:0] VAL_SIZE_1G = 8'h1B;
    localparam logic [DATA_W-1:0] VAL_IFW = 16'h0001;
    localparam logic [DATA_W-1:0] VAL_WBUF = 16'h000A;
    localparam logic [BYTE_W-1:0] VAL_REGION_CNT = 8'h01;
    localparam logic [BYTE_W-1:0] VAL_REGION_B0_128M = 8'h3F;
    localparam logic [BYTE_W-1:0] VAL_REGION_B0_256M = 8'h7F;
    localparam logic [BYTE_W-1:0] VAL_REGION_B0_BIG = 8'hFF;
    localparam logic [BYTE_W-1:0] VAL_REGION_B1_1G = 8'h01;
    localparam logic [BYTE_W-1:0] VAL_REGION_B3 = 8'h04;
    localparam logic [BYTE_W-1:0] VAL_EXT_P = 8'h50;
    localparam logic [BYTE_W-1:0] VAL_EXT_I = 8'h49;
    localparam logic [BYTE_W-1:0] VAL_EXT_MAJOR = 8'h31;
    localparam logic [BYTE_W-1:0] VAL_EXT_MINOR = 8'h34;
    localparam logic [BYTE_W-1:0] VAL_FEAT_B0_NONMUX = 8'hE6;
    localparam logic [BYTE_W-1:0] VAL_FEAT_B0_MUX = 8'h66;
    localparam logic [BYTE_W-1:0] VAL_FEAT_B1 = 8'h07;
    localparam logic [BYTE_W-1:0] VAL_SUSPEND = 8'h01;
    localparam logic [BYTE_W-1:0] VAL_BSW_MASK_LO = 8'h33;

    // Density selector
    typedef enum logic [1:0] {DENS_128M, DENS_256M, DENS_512M, DENS_1G} density_t;

endpackage : query_resp_pkg

// *** core/partition_mode_cell.sv ***
// Query mode flag for one partition
`timescale 1ns/1ns
module partition_mode_cell (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enter_query,
    input wire logic leave_query,
    output logic query_mode
);
    import query_resp_pkg::*;

    logic mode_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode_r <= MODE_QUERY_RESET;
        end else if (enter_query) begin
            mode_r <= 1'b1;
        end else if (leave_query) begin
            mode_r <= 1'b0;
        end
    end

    assign query_mode = mode_r;

endmodule : partition_mode_cell

// *** core/read_drive_port.sv ***
// Registered read data and output enable for the data bus
`timescale 1ns/1ns
module read_drive_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic read_en,
    input wire logic [query_resp_pkg::DATA_W-1:0] read_data,
    output logic [query_resp_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe
);
    import query_resp_pkg::*;

    logic [DATA_W-1:0] data_r;
    logic oe_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_r <= DATA_RESET;
        end else if (read_en) begin
            data_r <= read_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_r <= OE_RESET;
        end else begin
            oe_r <= read_en;
        end
    end

    assign dq_out = data_r;
    assign dq_oe = oe_r;

endmodule : read_drive_port

// *** core/flash_query_table_responder.sv ***
// Query database responder with per-partition query mode
// Operation
// - Query command enters query mode per partition
// - Read-array command leaves query mode
// - Database on low byte, upper byte zero
// - Database starts at word address 10h
// - Offsets 10h-12h return Q, R, Y
// - Multi-byte fields: low byte at lower address
// - Block offset 02h returns block state word
// - Block state bit 0 shows locked
// - Bit 1 shows lock-down; other bits reserved
// - Bit 1 meaning resolved as lock-down
// - Primary set identifier 00A5h, table pointer 010Ah
// - Alternate set identifier reads zero
// - Secondary table pointer reads zero
// - Supply limits 17, 20, 85, 95
// - Typical timeout exponents per field
// - Maximum timeout multipliers per field
// - Device size exponent by density
// - Extended table tag P R I, version 1.4
// - Optional feature bytes by bus variant
// - After-suspend function byte reads 01
// - Block state mask reads 33, 00
`timescale 1ns/1ns
module flash_query_table_responder #(
    parameter query_resp_pkg::density_t DENSITY = query_resp_pkg::DENS_512M,
    parameter bit ADMUX = 1'b0,
    parameter bit NODE_90NM = 1'b0
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic [query_resp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [query_resp_pkg::DATA_W-1:0] DQ_I,
    output logic [query_resp_pkg::DATA_W-1:0] DQ_O,
    output logic DQ_OE,
    input wire logic [query_resp_pkg::DATA_W-1:0] ARRAY_RDATA,
    input wire logic BLOCK_LOCKED,
    input wire logic BLOCK_LOCKDOWN,
    output logic [query_resp_pkg::PART_CNT-1:0] QUERY_MODE
);
    import query_resp_pkg::*;

    logic we_n_r;
    logic write_start;
    logic read_en;
    logic [PART_W-1:0] part_sel;
    logic [BLOCK_OFS_W-1:0] block_ofs;
    logic [DB_OFS_W-1:0] db_ofs;
    logic in_db_window;
    logic [PART_CNT-1:0] part_hit;
    logic [PART_CNT-1:0] query_mode;
    logic [BYTE_W-1:0] db_byte;
    logic [BYTE_W-1:0] block_state_word;
    logic [DATA_W-1:0] read_data;
    logic big_buf;

    // Write strobe: command taken on first cycle of a write
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            we_n_r <= WE_N_RESET;
        end else begin
            we_n_r <= WE_N;
        end
    end

    assign write_start = !CE_N && !WE_N && we_n_r;
    assign read_en = !CE_N && !OE_N && WE_N;

    // Address split: partition, offset within block, database offset
    assign part_sel = ADDR[ADDR_W-1 -: PART_W];
    assign block_ofs = ADDR[BLOCK_OFS_W-1:0];
    assign db_ofs = block_ofs[DB_OFS_W-1:0];
    assign in_db_window = (block_ofs[BLOCK_OFS_W-1:DB_OFS_W] == '0);

    // Per-partition query mode
    genvar gi;
    generate
        for (gi = 0; gi < PART_CNT; gi++) begin : g_part
            assign part_hit[gi] = (part_sel == PART_W'(gi));
            partition_mode_cell u_mode (
                .clk(REF_CLK),
                .rst_n(RESETN),
                .enter_query(write_start && part_hit[gi] && (DQ_I == CMD_QUERY)),
                .leave_query(write_start && part_hit[gi] && (DQ_I == CMD_READ_ARRAY)),
                .query_mode(query_mode[gi])
            );
        end
    endgenerate

    assign QUERY_MODE = query_mode;

    // Block state word
    always_comb begin
        block_state_word = BYTE_ZERO;
        block_state_word[BSW_LOCKED_BIT] = BLOCK_LOCKED;
        block_state_word[BSW_LOCKDOWN_BIT] = BLOCK_LOCKDOWN;
    end

    assign big_buf = NODE_90NM || (DENSITY == DENS_1G);

    // Query database lookup, one byte per word address
    always_comb begin
        db_byte = BYTE_ZERO;
        case (db_ofs)
            // Identification string
            OFS_SIG_Q: db_byte = VAL_SIG_Q;
            OFS_SIG_R: db_byte = VAL_SIG_R;
            OFS_SIG_Y: db_byte = VAL_SIG_Y;
            // Command set identifiers and table pointers
            OFS_PSET_LO: db_byte = VAL_PRIMARY_SET_ID[BYTE_W-1:0];
            OFS_PSET_HI: db_byte = VAL_PRIMARY_SET_ID[DATA_W-1:BYTE_W];
            OFS_PTAB_LO: db_byte = VAL_PRIMARY_TABLE[BYTE_W-1:0];
            OFS_PTAB_HI: db_byte = VAL_PRIMARY_TABLE[DATA_W-1:BYTE_W];
            OFS_ASET_LO: db_byte = VAL_ALTERNATE_SET_ID[BYTE_W-1:0];
            OFS_ASET_HI: db_byte = VAL_ALTERNATE_SET_ID[DATA_W-1:BYTE_W];
            OFS_STAB_LO: db_byte = VAL_SECONDARY_TABLE[BYTE_W-1:0];
            OFS_STAB_HI: db_byte = VAL_SECONDARY_TABLE[DATA_W-1:BYTE_W];
            // Supply limits
            OFS_VCC_MIN: db_byte = VAL_VCC_MIN;
            OFS_VCC_MAX: db_byte = VAL_VCC_MAX;
            OFS_VPP_MIN: db_byte = VAL_VPP_MIN;
            OFS_VPP_MAX: db_byte = VAL_VPP_MAX;
            // Typical timeouts
            OFS_TYP_WORD: db_byte = VAL_TYP_WORD;
            OFS_TYP_BUF: db_byte = big_buf ? VAL_TYP_BUF_LONG : VAL_TYP_BUF_SHORT;
            OFS_TYP_BLK: db_byte = VAL_TYP_BLK;
            OFS_TYP_CHIP: db_byte = VAL_TYP_CHIP;
            // Maximum timeout multipliers
            OFS_MAX_WORD: db_byte = VAL_MAX_WORD;
            OFS_MAX_BUF: begin
                // Only the 1-Gbit part at the newer node has the short multiplier
                if (!NODE_90NM && (DENSITY == DENS_1G)) begin
                    db_byte = VAL_MAX_BUF_NARROW;
                end else begin
                    db_byte = VAL_MAX_BUF_WIDE;
                end
            end
            OFS_MAX_BLK: db_byte = VAL_MAX_BLK;
            OFS_MAX_CHIP: db_byte = VAL_MAX_CHIP;
            // Geometry
            OFS_SIZE: begin
                case (DENSITY)
                    DENS_128M: db_byte = VAL_SIZE_128M;
                    DENS_256M: db_byte = VAL_SIZE_256M;
                    DENS_512M: db_byte = VAL_SIZE_512M;
                    DENS_1G: db_byte = VAL_SIZE_1G;
                    default: db_byte = BYTE_ZERO;
                endcase
            end
            OFS_IFW_LO: db_byte = VAL_IFW[BYTE_W-1:0];
            OFS_IFW_HI: db_byte = VAL_IFW[DATA_W-1:BYTE_W];
            OFS_WBUF_LO: db_byte = VAL_WBUF[BYTE_W-1:0];
            OFS_WBUF_HI: db_byte = VAL_WBUF[DATA_W-1:BYTE_W];
            OFS_REGION_CNT: db_byte = VAL_REGION_CNT;
            OFS_REGION_B0: begin
                case (DENSITY)
                    DENS_128M: db_byte = VAL_REGION_B0_128M;
                    DENS_256M: db_byte = VAL_REGION_B0_256M;
                    default: db_byte = VAL_REGION_B0_BIG;
                endcase
            end
            OFS_REGION_B1: begin
                db_byte = (DENSITY == DENS_1G) ? VAL_REGION_B1_1G : BYTE_ZERO;
            end
            OFS_REGION_B2: db_byte = BYTE_ZERO;
            OFS_REGION_B3: db_byte = VAL_REGION_B3;
            // Extended table
            OFS_EXT_P: db_byte = VAL_EXT_P;
            OFS_EXT_R: db_byte = VAL_SIG_R;
            OFS_EXT_I: db_byte = VAL_EXT_I;
            OFS_EXT_MAJOR: db_byte = VAL_EXT_MAJOR;
            OFS_EXT_MINOR: db_byte = VAL_EXT_MINOR;
            OFS_FEAT_B0: db_byte = ADMUX ? VAL_FEAT_B0_MUX : VAL_FEAT_B0_NONMUX;
            OFS_FEAT_B1: db_byte = VAL_FEAT_B1;
            OFS_FEAT_B2: db_byte = BYTE_ZERO;
            OFS_FEAT_B3: db_byte = BYTE_ZERO;
            OFS_SUSPEND: db_byte = VAL_SUSPEND;
            OFS_BSW_MASK_LO: db_byte = VAL_BSW_MASK_LO;
            OFS_BSW_MASK_HI: db_byte = BYTE_ZERO;
            default: db_byte = BYTE_ZERO;
        endcase
    end

    // Read data select; reads only steer the output register, never the query mode
    always_comb begin
        read_data = ARRAY_RDATA;
        if (query_mode[part_sel]) begin
            if (block_ofs == OFS_BLOCK_STATE) begin
                read_data = {UPPER_BYTE, block_state_word};
            end else if (in_db_window) begin
                read_data = {UPPER_BYTE, db_byte};
            end else begin
                read_data = {UPPER_BYTE, BYTE_ZERO};
            end
        end
    end

    read_drive_port u_drive (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .read_en(read_en),
        .read_data(read_data),
        .dq_out(DQ_O),
        .dq_oe(DQ_OE)
    );

endmodule : flash_query_table_responder

// *** tb/flash_array_model.sv ***
// Array word and block lock model behind the responder
`timescale 1ns/1ns
module flash_array_model (
    input wire logic [query_resp_pkg::ADDR_W-1:0] addr,
    output logic [query_resp_pkg::DATA_W-1:0] array_rdata,
    output logic block_locked,
    output logic block_lockdown
);
    import query_resp_pkg::*;
    // Word follows the address, so a stale or misrouted word shows
    assign array_rdata = addr[15:0] ^ 16'hC3A5;
    // Lock bits of the addressed block; reads never alter them
    assign block_locked = addr[17];
    assign block_lockdown = addr[18];
endmodule : flash_array_model

// *** tb/query_resp_sva.sv ***
// Port checker for the query responder
`timescale 1ns/1ns
module query_resp_sva #(
    parameter query_resp_pkg::density_t DENSITY = query_resp_pkg::DENS_512M,
    parameter bit ADMUX = 1'b0,
    parameter bit NODE_90NM = 1'b0
) (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic [query_resp_pkg::ADDR_W-1:0] ADDR,
    input wire logic [query_resp_pkg::DATA_W-1:0] DQ_I,
    input wire logic [query_resp_pkg::DATA_W-1:0] DQ_O,
    input wire logic DQ_OE,
    input wire logic [query_resp_pkg::DATA_W-1:0] ARRAY_RDATA,
    input wire logic BLOCK_LOCKED,
    input wire logic BLOCK_LOCKDOWN,
    input wire logic [query_resp_pkg::PART_CNT-1:0] QUERY_MODE
);
    import query_resp_pkg::*;
    logic we_n_prev_r;
    logic rd;
    logic wr;
    logic qm;
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            we_n_prev_r <= 1'b1;
        end else begin
            we_n_prev_r <= WE_N;
        end
    end
    assign rd = !CE_N && !OE_N && WE_N;
    assign wr = !CE_N && !WE_N && we_n_prev_r;
    assign qm = QUERY_MODE[ADDR[25:23]];
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    a_read_answer: assert property (rd |=> DQ_OE)
        else $error("read not answered");
    a_idle_release: assert property (!rd |=> !DQ_OE)
        else $error("bus driven without read");
    a_upper_zero: assert property (rd && qm |=> DQ_O[15:8] == UPPER_BYTE)
        else $error("upper byte not zero");
    a_sig_first: assert property (rd && qm && ADDR[16:0] == 17'h00010
        |=> DQ_O == 16'h0051)
        else $error("first signature byte wrong");
    a_table_ptr: assert property (rd && qm && ADDR[16:0] == 17'h00015
        |=> DQ_O == 16'h000A)
        else $error("table pointer low byte wrong");
    a_state_word: assert property (rd && qm && ADDR[16:0] == OFS_BLOCK_STATE
        |=> DQ_O == {14'h0000, $past(BLOCK_LOCKDOWN), $past(BLOCK_LOCKED)})
        else $error("block state word wrong");
    a_array_pass: assert property (rd && !qm |=> DQ_O == $past(ARRAY_RDATA))
        else $error("array word not passed");
    a_query_enter: assert property (wr && DQ_I == CMD_QUERY
        |=> QUERY_MODE[$past(ADDR[25:23])])
        else $error("query mode not entered");
    a_query_leave: assert property (wr && DQ_I == CMD_READ_ARRAY
        |=> !QUERY_MODE[$past(ADDR[25:23])])
        else $error("query mode not left");
    a_mode_quiet: assert property (!wr |=> $stable(QUERY_MODE))
        else $error("mode changed without command");
    c_query_read: cover property (rd && qm);
    c_state_read: cover property (rd && qm && ADDR[16:0] == OFS_BLOCK_STATE);
    c_enter: cover property (wr && DQ_I == CMD_QUERY);
    c_leave: cover property (wr && DQ_I == CMD_READ_ARRAY);
endmodule : query_resp_sva

bind flash_query_table_responder query_resp_sva #(
    .DENSITY(DENSITY), .ADMUX(ADMUX), .NODE_90NM(NODE_90NM)
) u_sva (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
    .ADDR(ADDR), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .ARRAY_RDATA(ARRAY_RDATA),
    .BLOCK_LOCKED(BLOCK_LOCKED), .BLOCK_LOCKDOWN(BLOCK_LOCKDOWN), .QUERY_MODE(QUERY_MODE)
);

// *** tb/flash_query_table_responder_tb_top.sv ***
// Self-checking bench for the query responder
`timescale 1ns/1ns
module flash_query_table_responder_tb_top;
    import query_resp_pkg::*;
    logic REF_CLK;
    logic RESETN;
    logic CE_N;
    logic OE_N;
    logic WE_N;
    logic [ADDR_W-1:0] ADDR;
    logic [DATA_W-1:0] DQ_I;
    logic [DATA_W-1:0] DQ_O;
    logic DQ_OE;
    logic [DATA_W-1:0] ARRAY_RDATA;
    logic BLOCK_LOCKED;
    logic BLOCK_LOCKDOWN;
    logic [PART_CNT-1:0] QUERY_MODE;
    logic [DATA_W-1:0] dq_o_alt;
    int err_count = 0;
    int compares = 0;
    logic [11:0] t_ofs [44] = '{12'h010, 12'h011, 12'h012, 12'h013, 12'h014, 12'h015,
        12'h016, 12'h017, 12'h018, 12'h019, 12'h01A, 12'h01B, 12'h01C, 12'h01D, 12'h01E,
        12'h01F, 12'h020, 12'h021, 12'h022, 12'h023, 12'h024, 12'h025, 12'h026, 12'h027,
        12'h028, 12'h029, 12'h02A, 12'h02B, 12'h10A, 12'h10B, 12'h10C, 12'h10D, 12'h10E,
        12'h10F, 12'h110, 12'h111, 12'h112, 12'h113, 12'h114, 12'h115, 12'h031, 12'h038,
        12'h050, 12'h1FF};
    logic [7:0] t_val [44] = '{8'h51, 8'h52, 8'h59, VAL_PRIMARY_SET_ID[7:0],
        VAL_PRIMARY_SET_ID[15:8], 8'h0A, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h20,
        8'h85, 8'h95, 8'h06, 8'h0A, 8'h0A, 8'h00, 8'h02, 8'h02, 8'h02, 8'h00, 8'h1A, 8'h01,
        8'h00, 8'h0A, 8'h00, 8'h50, 8'h52, 8'h49, 8'h31, 8'h34, 8'hE6, 8'h07, 8'h00, 8'h00,
        8'h01, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    flash_query_table_responder uut (.REF_CLK(REF_CLK), .RESETN(RESETN), .CE_N(CE_N),
        .OE_N(OE_N), .WE_N(WE_N), .ADDR(ADDR), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
        .ARRAY_RDATA(ARRAY_RDATA), .BLOCK_LOCKED(BLOCK_LOCKED),
        .BLOCK_LOCKDOWN(BLOCK_LOCKDOWN), .QUERY_MODE(QUERY_MODE));
    // Second build: largest density, multiplexed bus, shares every input
    flash_query_table_responder #(.DENSITY(DENS_1G), .ADMUX(1'b1), .NODE_90NM(1'b0)) u_alt (
        .REF_CLK(REF_CLK), .RESETN(RESETN), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N),
        .ADDR(ADDR), .DQ_I(DQ_I), .DQ_O(dq_o_alt), .DQ_OE(), .ARRAY_RDATA(ARRAY_RDATA),
        .BLOCK_LOCKED(BLOCK_LOCKED), .BLOCK_LOCKDOWN(BLOCK_LOCKDOWN), .QUERY_MODE());
    flash_array_model u_array (.addr(ADDR), .array_rdata(ARRAY_RDATA),
        .block_locked(BLOCK_LOCKED), .block_lockdown(BLOCK_LOCKDOWN));

    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end

    function automatic logic [ADDR_W-1:0] mk(input int p, input int b, input int o);
        return {3'(p), 6'(b), 17'(o)};
    endfunction : mk

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic chk_flags(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_flags

    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge REF_CLK);
        CE_N <= 1'b0;
        WE_N <= 1'b0;
        ADDR <= a;
        DQ_I <= d;
        @(posedge REF_CLK);
        CE_N <= 1'b1;
        WE_N <= 1'b1;
        DQ_I <= ~d;
        #1;
    endtask : bus_write

    task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge REF_CLK);
        CE_N <= 1'b0;
        OE_N <= 1'b0;
        ADDR <= a;
        @(posedge REF_CLK);
        CE_N <= 1'b1;
        OE_N <= 1'b1;
        #1;
        chk_word("read data", exp, DQ_O);
        chk_flags("drive enable", 8'h01, {7'h00, DQ_OE});
    endtask : read_chk

    task automatic table_walk(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            read_chk(mk(3, i, t_ofs[i]), {8'h00, t_val[i]});
        end
    endtask : table_walk

    task automatic t_reset;
        chk_flags("mode after reset", 8'h00, QUERY_MODE);
        chk_word("data after reset", 16'h0000, DQ_O);
        read_chk(mk(0, 1, 16), 16'(mk(0, 1, 16)) ^ 16'hC3A5);
        $display("test reset done");
    endtask : t_reset

    task automatic t_query_table;
        bus_write(mk(3, 0, 0), 16'h0098);
        chk_flags("mode enter", 8'h08, QUERY_MODE);
        table_walk(0, 10);
        table_walk(11, 27);
        table_walk(28, 39);
        table_walk(40, 43);
        read_chk(mk(3, 9, 12'h200), 16'h0000);
        chk_flags("mode after reads", 8'h08, QUERY_MODE);
        $display("test query table done");
    endtask : t_query_table

    task automatic t_variant;
        logic [8:0] ofs [6] = '{9'h020, 9'h024, 9'h027, 9'h10F, 9'h02D, 9'h02E};
        logic [7:0] alt [6] = '{8'h0B, 8'h01, 8'h1B, 8'h66, 8'hFF, 8'h01};
        logic [7:0] dflt [6] = '{8'h0A, 8'h02, 8'h1A, 8'hE6, 8'hFF, 8'h00};
        for (int i = 0; i < 6; i++) begin
            read_chk(mk(3, 1, ofs[i]), {8'h00, dflt[i]});
            chk_word("variant read data", {8'h00, alt[i]}, dq_o_alt);
        end
        $display("test variant done");
    endtask : t_variant

    task automatic t_block_state;
        for (int k = 0; k < 4; k++) begin
            read_chk(mk(3, k + 4, 2), {14'h0000, 2'(k)});
        end
        read_chk(mk(5, 3, 2), 16'(mk(5, 3, 2)) ^ 16'hC3A5);
        $display("test block state done");
    endtask : t_block_state

    task automatic t_commands;
        bus_write(mk(3, 0, 0), 16'h0070);
        chk_flags("other code", 8'h08, QUERY_MODE);
        bus_write(mk(5, 2, 0), 16'h0098);
        chk_flags("second partition", 8'h28, QUERY_MODE);
        read_chk(mk(5, 2, 17), 16'h0052);
        bus_write(mk(3, 0, 0), 16'h00FF);
        chk_flags("leave query", 8'h20, QUERY_MODE);
        read_chk(mk(3, 0, 16), 16'(mk(3, 0, 16)) ^ 16'hC3A5);
        $display("test commands done");
    endtask : t_commands

    task automatic t_mid_reset;
        @(posedge REF_CLK);
        RESETN <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RESETN <= 1'b1;
        #1;
        chk_flags("mode after second reset", 8'h00, QUERY_MODE);
        chk_word("data after second reset", 16'h0000, DQ_O);
        read_chk(mk(5, 2, 16), 16'(mk(5, 2, 16)) ^ 16'hC3A5);
        $display("test mid reset done");
    endtask : t_mid_reset

    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    initial begin
        repeat (5000) @(posedge REF_CLK);
        err_count++;
        results();
    end

    initial begin
        RESETN = 1'b0;
        CE_N = 1'b1;
        OE_N = 1'b1;
        WE_N = 1'b1;
        ADDR = '0;
        DQ_I = 16'h0000;
        repeat (2) @(posedge REF_CLK);
        RESETN <= 1'b1;
        #1;
        t_reset();
        t_query_table();
        t_variant();
        t_block_state();
        t_commands();
        t_mid_reset();
        results();
    end
endmodule : flash_query_table_responder_tb_top
